/* eswp_pkg.sv */
// Purpose: shared constants and types of the serial eeprom write-protect block
// Assumes: core clock of 20 MHz; byte-wide two-wire link
// Notes: every number used by more than one file lives here
package eswp_pkg;

  // ==========================================================
  // address byte codes and protect commands
  localparam logic [3:0] CODE_MEM = 4'ha;   // normal reads and writes
  localparam logic [3:0] CODE_PROT = 4'h6;  // protection register access
  localparam logic [7:0] CMD_SET_PERM = 8'h01;
  localparam logic [7:0] CMD_SET_REV = 8'h02;
  localparam logic [7:0] CMD_CLR_REV = 8'h03;

  // ==========================================================
  // array layout
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_IDX_W = 4;
  localparam int ADDR_W = 8;
  localparam int PROT_HALF_BIT = 7;   // address bit that splits the halves

  // ==========================================================
  // link bit counting
  localparam logic [3:0] LAST_DATA_CNT = 4'h7;
  localparam logic [3:0] ACK_CNT = 4'h8;

  // ==========================================================
  // timing
  localparam int CORE_CLK_MHZ = 20;
  localparam int TWR_US = 5000;                          // write cycle, longest
  localparam int TWR_CYCLES = TWR_US * CORE_CLK_MHZ;     // exact integer product, no rounding

  // ==========================================================
  // reset values
  localparam logic FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_PCMD,
    ST_PDATA,
    ST_READ,
    ST_SKIP
  } eswp_state_t;

endpackage

/* eswp_link_if.sv */
// Purpose: carrier between the core-clock logic and the serial-clock logic
// Assumes: byte_tgl is a toggle; rx_byte is stable while the toggle is seen
// Notes: core drives control levels, link drives the received byte and pin pull
`timescale 1ns/1ps
`default_nettype none
interface eswp_link_if;
  logic frame_rst_n;
  logic ack_en;
  logic tx_mode;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic byte_tgl;
  logic pull;

  modport core (
    output frame_rst_n,
    output ack_en,
    output tx_mode,
    output tx_byte,
    input rx_byte,
    input byte_tgl,
    input pull
  );

  modport link (
    input frame_rst_n,
    input ack_en,
    input tx_mode,
    input tx_byte,
    output rx_byte,
    output byte_tgl,
    output pull
  );
endinterface
`default_nettype wire

/* eswp_link.sv */
// Purpose: serial-clock side: shift in bits, acknowledge, shift out read data
// Assumes: frame_rst_n pulses low at every start, while the serial clock is high
// Notes: pull is the open-drain enable; the pin itself is only ever pulled low
`timescale 1ns/1ps
`default_nettype none
module eswp_link (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic resetn_i,
  eswp_link_if.link lk
);

  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic tx_stop_q;
  logic tgl_q;
  logic [2:0] bit_sel;

  // ==========================================================
  // rising edge: sample bits
  always_ff @(posedge scl_i or negedge lk.frame_rst_n) begin
    if (!lk.frame_rst_n) begin
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_stop_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[6:0], sda_i};
      if (cnt_q == eswp_pkg::ACK_CNT) begin
        cnt_q <= 4'h0;
        // master left the ack high: stop sending
        if (lk.tx_mode && sda_i) begin
          tx_stop_q <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // word handover, kept across starts so the toggle never jumps
  always_ff @(posedge scl_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_q <= 1'b0;
      lk.rx_byte <= 8'h00;
    end else if (cnt_q == eswp_pkg::LAST_DATA_CNT) begin
      lk.rx_byte <= {shift_q[6:0], sda_i};
      tgl_q <= ~tgl_q;
    end
  end

  assign lk.byte_tgl = tgl_q;
  assign bit_sel = 3'h7 - cnt_q[2:0];

  // ==========================================================
  // falling edge: change outgoing bit
  always_ff @(negedge scl_i or negedge lk.frame_rst_n) begin
    if (!lk.frame_rst_n) begin
      lk.pull <= 1'b0;
    end else if (cnt_q == eswp_pkg::ACK_CNT) begin
      lk.pull <= lk.ack_en;
    end else begin
      // release or pull only, never drive high
      lk.pull <= lk.tx_mode && !tx_stop_q && !lk.tx_byte[bit_sel];
    end
  end

endmodule // eswp_link
`default_nettype wire

/* eswp_top.sv */
// Purpose: two-wire serial eeprom, 256 x 8, with hardware and software write protect
// Assumes: scl_i is the master's clock; straps and protect pin are slow levels
// Notes: flag state is restored from nv_*_i after reset and exported for retention
// Behaviour
// - sample on rising, change on falling clock
// - data line only pulled low or released
// - three straps give eight distinct addresses
// - selected only when received bits match straps
// - floating strap reads as zero
// - protect pin high blocks every array write
// - no protection: reads and writes everywhere
// - any software flag locks 00H to 7FH
// - permanent flag never cleared once set
// - reversible flag set and cleared by commands
// - array holds 256 bytes of 8 bits
// - page writes up to 16, partial allowed
// - self-timed programming, at most 5 ms
// - bus query shows software protection state
// - codes 1010 memory, 0110 protect; read high
// - no ack of 0110 after permanent set
// - protected write acked, data kept, timed
// - ack by pulling low on ninth clock
`timescale 1ns/1ps
`default_nettype none
module eswp_top #(
  parameter int TWR_CYCLES = eswp_pkg::TWR_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_addr_strap_0_i,
  input wire logic chip_addr_strap_1_i,
  input wire logic chip_addr_strap_2_i,
  input wire logic wp_i,
  input wire logic nv_perm_i,
  input wire logic nv_rev_i,
  output logic prot_perm_o,
  output logic prot_rev_o,
  output logic busy_o
);

  localparam int TMR_W = $clog2(TWR_CYCLES + 1);
  localparam int IDX_W = eswp_pkg::PAGE_IDX_W + 1;

  eswp_link_if lk ();

  // ==========================================================
  // serial-clock side
  eswp_link u_link (
    .scl_i(scl_i),
    .sda_i(sda_i),
    .resetn_i(resetn_i),
    .lk(lk.link)
  );

  // ==========================================================
  // functions
  // write permission of one byte address
  function automatic logic wr_allowed(input logic [7:0] addr, input logic wp,
                                      input logic perm, input logic rev);
    logic low_half;
    low_half = !addr[eswp_pkg::PROT_HALF_BIT];
    wr_allowed = !wp && !(low_half && (perm || rev));
  endfunction

  // ==========================================================
  // synchronisers: scl, sda, wp, straps, byte toggle
  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic tgl_s;
  logic scl_p_q;
  logic sda_p_q;
  logic tgl_seen_q;

  // two flops before any use
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 7'h00;
      sync_q <= 7'h00;
    end else begin
      meta_q <= {lk.byte_tgl, chip_addr_strap_2_i, chip_addr_strap_1_i,
                 chip_addr_strap_0_i, wp_i, sda_i, scl_i};
      sync_q <= meta_q;
    end
  end

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign wp_s = sync_q[2];              // undriven pin pulled low outside
  assign strap_s = sync_q[5:3];
  assign tgl_s = sync_q[6];

  // previous samples for edge detection
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b1;
      tgl_seen_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      tgl_seen_q <= tgl_s;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic byte_ev;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign byte_ev = tgl_s ^ tgl_seen_q;

  // ==========================================================
  // storage
  logic [7:0] mem [eswp_pkg::MEM_WORDS];
  logic [7:0] wbuf [eswp_pkg::PAGE_BYTES];

  // ==========================================================
  // protocol state
  eswp_pkg::eswp_state_t st_q;
  logic [7:0] addr_q;
  logic [eswp_pkg::PAGE_BYTES-1:0] valid_q;
  logic [7:0] pcmd_q;
  logic ppend_q;
  logic clr_q;
  logic ack_q;
  logic txm_q;
  logic [7:0] txb_q;
  logic busy_q;
  logic prog_done;
  logic perm_q;
  logic rev_q;
  logic [7:0] rx;
  logic sel;
  logic [3:0] woff;

  assign rx = lk.rx_byte;
  assign sel = (rx[3:1] == strap_s);
  assign woff = addr_q[3:0];
  assign lk.frame_rst_n = resetn_i && !clr_q;
  assign lk.ack_en = ack_q;
  assign lk.tx_mode = txm_q;
  assign lk.tx_byte = txb_q;

  // start, stop and received-word handling
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= eswp_pkg::ST_IDLE;
      addr_q <= 8'h00;
      pcmd_q <= 8'h00;
      clr_q <= 1'b0;
      ack_q <= 1'b0;
      txm_q <= 1'b0;
      txb_q <= 8'h00;
    end else begin
      clr_q <= start_ev;
      if (start_ev) begin
        st_q <= eswp_pkg::ST_DEV;
        ack_q <= 1'b0;
        txm_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= eswp_pkg::ST_IDLE;
        ack_q <= 1'b0;
        txm_q <= 1'b0;
      end else if (byte_ev) begin
        case (st_q)
          eswp_pkg::ST_DEV: begin
            st_q <= eswp_pkg::ST_SKIP;
            ack_q <= 1'b0;
            if (busy_q) begin
              // inputs ignored while programming
              st_q <= eswp_pkg::ST_SKIP;
            end else if (rx[7:4] == eswp_pkg::CODE_MEM && sel) begin
              ack_q <= 1'b1;
              if (rx[0]) begin
                txm_q <= 1'b1;
                txb_q <= mem[addr_q];
                st_q <= eswp_pkg::ST_READ;
              end else begin
                st_q <= eswp_pkg::ST_WADDR;
              end
            end else if (rx[7:4] == eswp_pkg::CODE_PROT && sel && !perm_q) begin
              if (rx[0]) begin
                ack_q <= !rev_q;
              end else begin
                ack_q <= 1'b1;
                st_q <= eswp_pkg::ST_PCMD;
              end
            end
          end
          eswp_pkg::ST_WADDR: begin
            addr_q <= rx;
            st_q <= eswp_pkg::ST_WDATA;
          end
          eswp_pkg::ST_WDATA: begin
            // offset rolls over inside the page
            addr_q <= {addr_q[7:4], woff + 4'h1};
          end
          eswp_pkg::ST_PCMD: begin
            pcmd_q <= rx;
            st_q <= eswp_pkg::ST_PDATA;
          end
          eswp_pkg::ST_READ: begin
            ack_q <= 1'b0;
            addr_q <= addr_q + 8'h01;
            txb_q <= mem[addr_q + 8'h01];
          end
          eswp_pkg::ST_PDATA: begin
            ack_q <= 1'b1;
          end
          eswp_pkg::ST_SKIP: begin
            ack_q <= 1'b0;
          end
          default: begin
            st_q <= eswp_pkg::ST_IDLE;
            ack_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // page buffer and pending work
  logic wbuf_we;
  logic commit_go;
  assign wbuf_we = byte_ev && !start_ev && !stop_ev && st_q == eswp_pkg::ST_WDATA;
  assign commit_go = stop_ev && !busy_q
                     && ((st_q == eswp_pkg::ST_WDATA && |valid_q)
                         || st_q == eswp_pkg::ST_PDATA);

  // page buffer data
  always_ff @(posedge core_clk_i) begin
    if (wbuf_we) begin
      wbuf[woff] <= rx;
    end
  end

  // valid bits and protect command, kept through programming
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_q <= '0;
      ppend_q <= 1'b0;
    end else if (prog_done || (start_ev && !busy_q)) begin
      valid_q <= '0;
      ppend_q <= 1'b0;
    end else if (wbuf_we) begin
      valid_q[woff] <= 1'b1;
    end else if (commit_go && st_q == eswp_pkg::ST_PDATA) begin
      ppend_q <= 1'b1;
    end
  end

  // ==========================================================
  // self-timed programming cycle
  logic [TMR_W-1:0] tmr_q;
  logic [IDX_W-1:0] idx_q;
  logic [3:0] page_q;
  logic [3:0] idx_lo;
  logic [7:0] prog_addr;
  logic prog_we;

  assign prog_done = busy_q && tmr_q == '0;
  assign idx_lo = idx_q[3:0];
  assign prog_addr = {page_q, idx_lo};
  // protection judged per byte as it commits
  assign prog_we = busy_q && !idx_q[IDX_W-1] && !ppend_q && valid_q[idx_lo]
                   && wr_allowed(prog_addr, wp_s, perm_q, rev_q);

  // cycle timer, runs full length even when nothing is stored
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      idx_q <= '0;
      page_q <= 4'h0;
    end else if (commit_go) begin
      busy_q <= 1'b1;
      tmr_q <= TMR_W'(TWR_CYCLES - 1);
      idx_q <= '0;
      page_q <= addr_q[7:4];
    end else if (busy_q) begin
      tmr_q <= tmr_q - TMR_W'(1);
      if (!idx_q[IDX_W-1]) begin
        idx_q <= idx_q + IDX_W'(1);
      end
      if (prog_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // array write port
  always_ff @(posedge core_clk_i) begin
    if (prog_we) begin
      mem[prog_addr] <= wbuf[idx_lo];
    end
  end

  // ==========================================================
  // protection flags, restored once after reset release
  logic loaded_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loaded_q <= 1'b0;
      perm_q <= eswp_pkg::FLAG_RST;
      rev_q <= eswp_pkg::FLAG_RST;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      perm_q <= nv_perm_i;
      rev_q <= nv_rev_i;
    end else if (prog_done && ppend_q) begin
      case (pcmd_q)
        eswp_pkg::CMD_SET_PERM: perm_q <= 1'b1;
        eswp_pkg::CMD_SET_REV: rev_q <= 1'b1;
        eswp_pkg::CMD_CLR_REV: rev_q <= 1'b0;
        default: rev_q <= rev_q;
      endcase
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o <= 1'b0;
      prot_perm_o <= eswp_pkg::FLAG_RST;
      prot_rev_o <= eswp_pkg::FLAG_RST;
      busy_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      prot_perm_o <= perm_q;
      prot_rev_o <= rev_q;
      busy_o <= busy_q;
    end
  end

  assign sda_oe_o = lk.pull;

endmodule // eswp_top
`default_nettype wire

/* eswp_assertions.sv */
// Purpose: port-level checks of the eeprom write-protect block
// Assumes: top-level ports only
// Notes: bound into eswp_top
`timescale 1ns/1ps
`default_nettype none
module eswp_assertions #(
  parameter int TWR_CYCLES = 40
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic nv_perm_i,
  input wire logic nv_rev_i,
  input wire logic prot_perm_o,
  input wire logic prot_rev_o,
  input wire logic busy_o
);
  // ==========================================
  int busy_cnt_q;
  logic [1:0] up_q;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // length of the running write cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_o ? busy_cnt_q + 1 : 0;
    end
  end
  // cycles since reset, saturating
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  a_oe_falling_edge: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pull changed with clock high");
  a_drive_low_only: assert property (sda_oe_o |-> sda_o == 1'h0)
    else $error("data line driven high");
  a_perm_sticky: assert property (prot_perm_o |=> prot_perm_o)
    else $error("permanent flag cleared");
  a_cycle_length: assert property ($fell(busy_o) |->
    busy_cnt_q >= TWR_CYCLES && busy_cnt_q <= TWR_CYCLES + 1)
    else $error("write cycle length wrong");
  a_quiet_busy: assert property (busy_o && $past(busy_o) |-> !sda_oe_o)
    else $error("answer during write cycle");
  // flags load at the first edge after release and reach the pins one edge later
  a_nv_restore: assert property ($rose(resetn_i) |-> ##2
    prot_perm_o == $past(nv_perm_i, 2) && prot_rev_o == $past(nv_rev_i, 2))
    else $error("flags not restored");
  a_flags_hold_busy: assert property (busy_o && $past(busy_o) |->
    $stable({prot_perm_o, prot_rev_o}))
    else $error("flag moved inside write cycle");
  a_flags_after_cycle: assert property ($changed({prot_perm_o, prot_rev_o})
    && up_q == 2'h3 |-> $past(busy_o) || $past(busy_o, 2))
    else $error("flag moved without write cycle");
  c_cycle: cover property ($rose(busy_o));
  c_perm: cover property ($rose(prot_perm_o));
  c_rev_clr: cover property ($fell(prot_rev_o));
endmodule // eswp_assertions
bind eswp_top eswp_assertions #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .nv_perm_i(nv_perm_i),
  .nv_rev_i(nv_rev_i), .prot_perm_o(prot_perm_o),
  .prot_rev_o(prot_rev_o), .busy_o(busy_o));
`default_nettype wire

/* eswp_master.sv */
// Purpose: two-wire bus master model
// Assumes: open-drain data line with pull-up
// Notes: clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module eswp_master #(
  parameter int H = 616
) (
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  // ==========================================
  logic [7:0] res;
  event done;
  initial begin
    scl_o = 1'h1;
    pull_o = 1'h0;
  end
  // one clock: data moves while low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    #H pull_o = !b;
    #H scl_o = 1'h1;
    r = sda_i;
    #H scl_o = 1'h0;
  endtask
  task automatic start;
    #H pull_o = 1'h0;
    #H scl_o = 1'h1;
    #H pull_o = 1'h1;
    #H scl_o = 1'h0;
  endtask
  task automatic stop;
    #H pull_o = 1'h1;
    #H scl_o = 1'h1;
    #H pull_o = 1'h0;
    #H;
  endtask
  // send a byte, report the acknowledge
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    res = {7'h0, !r};
    ->done;
  endtask
  // take a byte, then ack or nack
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(last, r);
    res = d;
    ->done;
  endtask
endmodule // eswp_master
`default_nettype wire

/* test_serial_eeprom_write_protect.sv */
// Purpose: self-checking bench of the eeprom write-protect block
// Assumes: master model on the serial pins
// Notes: shortened write cycle
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_write_protect;
  // ==========================================
  localparam int TW = 500;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [2:0] strap = 3'h0;
  logic wp = 1'h0;
  logic nvp = 1'h0;
  logic nvr = 1'h0;
  logic pm = 1'h0;
  logic rm = 1'h0;
  wire logic scl, pull, sda, oe, so, perm, rev, busy;
  int bad_count = 0;
  int checks = 0;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  always #25 clk = ~clk;
  assign sda = !(pull || (oe && !so));
  eswp_top #(.TWR_CYCLES(TW)) uut (.core_clk_i(clk), .resetn_i(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(so), .sda_oe_o(oe),
    .chip_addr_strap_0_i(strap[0]), .chip_addr_strap_1_i(strap[1]),
    .chip_addr_strap_2_i(strap[2]), .wp_i(wp), .nv_perm_i(nvp),
    .nv_rev_i(nvr), .prot_perm_o(perm), .prot_rev_o(rev), .busy_o(busy));
  eswp_master m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // compare each link result with the oldest note
  always @(m.done) begin
    check("link", m.res, exp_q.pop_front());
  end
  function automatic logic [7:0] dev(input logic [3:0] c, input logic r);
    return {c, strap, r};
  endfunction
  task automatic put(input logic [7:0] b, input logic a);
    exp_q.push_back({7'h0, a});
    m.wbyte(b);
  endtask
  // wait out the self-timed cycle
  task automatic cyc;
    int k;
    for (k = 0; k < 20 && busy !== 1'h1; k++) @(negedge clk);
    check("busy", {7'h0, busy}, 8'h01);
    for (k = 0; k < TW + 4 && busy !== 1'h0; k++) @(negedge clk);
    check("done", {7'h0, busy}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    logic [7:0] t;
    m.start();
    put(dev(eswp_pkg::CODE_MEM, 1'h0), 1'h1);
    put(a, 1'h1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      t = {a[7:4], a[3:0] + i[3:0]};
      put(d, 1'h1);
      if (!(wp || (!t[7] && (pm || rm)))) mem[t] = d;
    end
    m.stop();
    m.start();
    put(dev(eswp_pkg::CODE_MEM, 1'h0), 1'h0);
    m.stop();
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    m.start();
    put(dev(eswp_pkg::CODE_MEM, 1'h0), 1'h1);
    put(a, 1'h1);
    m.start();
    put(dev(eswp_pkg::CODE_MEM, 1'h1), 1'h1);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[a + i[7:0]]);
      m.rbyte(i == n - 1);
    end
    m.stop();
  endtask
  task automatic pcmd(input logic [7:0] c, input logic a);
    m.start();
    put(dev(eswp_pkg::CODE_PROT, 1'h0), a);
    if (a) begin
      put(c, 1'h1);
    end
    m.stop();
    if (a) cyc();
  endtask
  task automatic query(input logic a);
    m.start();
    put(dev(eswp_pkg::CODE_PROT, 1'h1), a);
    m.stop();
  endtask
  task automatic flags;
    check("perm", {7'h0, perm}, {7'h0, pm});
    check("rev", {7'h0, rev}, {7'h0, rm});
  endtask
  initial begin
    void'($urandom(19));
    repeat (16) @(posedge clk);
    strap <= 3'($urandom);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    flags();
    m.start();
    put({eswp_pkg::CODE_MEM, ~strap, 1'h0}, 1'h0);
    m.stop();
    query(1'h1);
    wr(8'h7e, 3);
    rd(8'h7e, 2);
    rd(8'h70, 1);
    wr(8'hf0, 16);
    rd(8'hf0, 16);
    pcmd(eswp_pkg::CMD_SET_REV, 1'h1);
    rm = 1'h1;
    flags();
    query(1'h0);
    wr(8'h7e, 2);
    wr(8'hf1, 1);
    rd(8'h7e, 2);
    rd(8'hf1, 1);
    pcmd(eswp_pkg::CMD_CLR_REV, 1'h1);
    rm = 1'h0;
    flags();
    @(posedge clk) wp <= 1'h1;
    wr(8'hf2, 1);
    @(posedge clk) wp <= 1'h0;
    rd(8'hf2, 1);
    pcmd(eswp_pkg::CMD_SET_PERM, 1'h1);
    pm = 1'h1;
    pcmd(eswp_pkg::CMD_CLR_REV, 1'h0);
    flags();
    wr(8'h70, 1);
    rd(8'h70, 1);
    @(posedge clk) rst_n <= 1'h0;
    nvr <= 1'h1;
    nvp <= 1'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rm = 1'h1;
    repeat (6) @(posedge clk);
    flags();
    report_and_stop();
  end
  // cut a hang short
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule // test_serial_eeprom_write_protect
`default_nettype wire
